//--- design/cmf_pkg.sv
// Shared field positions, selects, reset values and states of the message FIFO control block
package cmf_pkg;
  // Control word field positions
  localparam int CTL_RESET_BIT = 10;
  localparam int CTL_SEND_BIT = 9;
  localparam int CTL_ADVANCE_BIT = 8;
  localparam int CTL_DIR_BIT = 7;
  localparam int CTL_AUTO_RTR_BIT = 6;
  localparam int CTL_TS_EN_BIT = 5;
  localparam int CTL_ATT_IE_BIT = 4;
  localparam int CTL_OVF_IE_BIT = 3;
  localparam int CTL_EF_IE_BIT = 2;
  localparam int CTL_HALF_IE_BIT = 1;
  localparam int CTL_NFNE_IE_BIT = 0;
  // Status word field positions
  localparam int STA_INDEX_LSB = 8;
  localparam int INDEX_W = 5;
  localparam int STA_ABORTED_BIT = 7;
  localparam int STA_ARB_BIT = 6;
  localparam int STA_BUSERR_BIT = 5;
  localparam int STA_ATT_BIT = 4;
  localparam int STA_OVF_BIT = 3;
  localparam int STA_EF_BIT = 2;
  localparam int STA_HALF_BIT = 1;
  localparam int STA_NFNE_BIT = 0;
  // Byte lanes of the register word
  localparam int LANE_LOW = 0;
  localparam int LANE_HIGH = 1;
  localparam int WORD_W = 32;
  localparam int BE_W = 4;
  // Register selects
  localparam logic SEL_CONTROL = 1'h0;
  localparam logic SEL_STATUS = 1'h1;
  // Reset values
  localparam logic [WORD_W-1:0] WORD_RESET = 32'h0;
  localparam logic [INDEX_W-1:0] INDEX_RESET = 5'h0;
  // Reset sequencing, Gray along config -> clear -> idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CLEAR = 2'h1,
    ST_CFG = 2'h3
  } cmf_state_t;
endpackage

//--- design/cmf_ptr.sv
// Ring pointer over the message slots of one FIFO
`timescale 1ns/1ns
module cmf_ptr #(
  parameter int SLOT_W = 5
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic inc,
  input wire logic [SLOT_W-1:0] lastSlot,
  output logic [SLOT_W-1:0] value
);
  typedef struct packed {
    logic [SLOT_W-1:0] value;
  } cmf_ptr_state_t;

  cmf_ptr_state_t s_r;
  cmf_ptr_state_t s_nxt;

  function automatic logic [SLOT_W-1:0] nextSlot(input logic [SLOT_W-1:0] cur,
                                                 input logic [SLOT_W-1:0] last);
    nextSlot = (cur >= last) ? '0 : SLOT_W'(cur + 1'b1);
  endfunction

  always_comb
  begin
    s_nxt = s_r;
    if (clr)
    begin
      s_nxt.value = '0;
    end
    else if (inc)
    begin
      s_nxt.value = nextSlot(s_r.value, lastSlot);
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign value = s_r.value;
endmodule

//--- design/cmf_buf.sv
// Small word FIFO with valid and ready on both sides
`timescale 1ns/1ns
module cmf_buf #(
  parameter int WIDTH = 37,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
    begin : g_bad
      $error("cmf_buf needs a power-of-two depth of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [PTR_W:0] count;
  } cmf_buf_state_t;

  cmf_buf_state_t s_r;
  cmf_buf_state_t s_nxt;
  logic push;
  logic pop;

  assign inReady = (s_r.count != (PTR_W+1)'(DEPTH));
  assign outValid = (s_r.count != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = s_r.mem[s_r.rdPtr];

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wrPtr] = inData;
      s_nxt.wrPtr = PTR_W'(s_r.wrPtr + 1'b1);
    end
    if (pop)
    begin
      s_nxt.rdPtr = PTR_W'(s_r.rdPtr + 1'b1);
    end
    s_nxt.count = (PTR_W+1)'(s_r.count + push - pop);
    if (flush)
    begin
      s_nxt.wrPtr = '0;
      s_nxt.rdPtr = '0;
      s_nxt.count = '0;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
endmodule

//--- design/cmf_ctrl.sv
// Control and status logic of one transmit or receive message FIFO
`timescale 1ns/1ns
module cmf_ctrl #(
  parameter int BUF_DEPTH = 4,
  parameter int TS_W = 32
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic configMode,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic regSel,
  input wire logic [cmf_pkg::BE_W-1:0] regByteEn,
  input wire logic [cmf_pkg::WORD_W-1:0] regWdata,
  output logic [cmf_pkg::WORD_W-1:0] regRdata,
  input wire logic [cmf_pkg::INDEX_W-1:0] lastSlot,
  input wire logic txSent,
  input wire logic txAborted,
  input wire logic txArbLost,
  input wire logic txBusError,
  input wire logic txAttemptsExhausted,
  input wire logic remoteReqRcvd,
  input wire logic rxStore,
  output logic rxStoreReady,
  input wire logic [TS_W-1:0] rxTimestamp,
  output logic sendRequest,
  output logic abortReq,
  output logic resetBusy,
  output logic txDirection,
  output logic [cmf_pkg::INDEX_W-1:0] headIdx,
  output logic [cmf_pkg::INDEX_W-1:0] tailIdx,
  output logic [cmf_pkg::INDEX_W-1:0] msgIndex,
  output logic irqReq,
  output logic stampValid,
  input wire logic stampReady,
  output logic [cmf_pkg::INDEX_W+TS_W-1:0] stampData
);
  localparam int SW = cmf_pkg::INDEX_W;
  localparam int CW = SW + 1;

  generate
    if (TS_W < 1 || TS_W > cmf_pkg::WORD_W)
    begin : g_bad_ts
      $error("cmf_ctrl time stamp width must be 1 to 32");
    end
  endgenerate

  typedef struct packed {
    cmf_pkg::cmf_state_t st;
    logic txDir;
    logic autoReply;
    logic tsEn;
    logic attIe;
    logic ovfIe;
    logic efIe;
    logic halfIe;
    logic nfneIe;
    logic sendReq;
    logic aborted;
    logic arbLost;
    logic busErr;
    logic attFlag;
    logic ovfFlag;
    logic pendArb;
    logic pendErr;
    logic [CW-1:0] count;
    logic abortPulse;
    logic irq;
    logic [cmf_pkg::WORD_W-1:0] rdata;
  } cmf_ctrl_state_t;

  cmf_ctrl_state_t s_r;
  cmf_ctrl_state_t s_nxt;

  logic resetting;
  logic ctrlWr;
  logic statWr;
  logic advReq;
  logic rxAcc;
  logic [CW-1:0] depth;
  logic isFull;
  logic isEmpty;
  logic efLevel;
  logic halfLevel;
  logic nfneLevel;
  logic headInc;
  logic tailInc;
  logic overflowEv;
  logic bufInReady;
  logic bufPush;

  // Half empty for transmit, half full for receive
  function automatic logic halfCond(input logic [CW-1:0] cnt, input logic [CW-1:0] dep,
                                    input logic tx);
    halfCond = tx ? ({cnt, 1'b0} <= {1'b0, dep}) : ({cnt, 1'b0} >= {1'b0, dep});
  endfunction

  assign resetting = (s_r.st != cmf_pkg::ST_IDLE);
  assign ctrlWr = regWrite && (regSel == cmf_pkg::SEL_CONTROL);
  assign statWr = regWrite && (regSel == cmf_pkg::SEL_STATUS);
  assign advReq = ctrlWr && regByteEn[cmf_pkg::LANE_HIGH]
                  && regWdata[cmf_pkg::CTL_ADVANCE_BIT] && !resetting;
  assign depth = CW'({1'b0, lastSlot} + 1'b1);
  assign isFull = (s_r.count >= depth);
  assign isEmpty = (s_r.count == '0);
  assign rxAcc = rxStore && rxStoreReady && !s_r.txDir && !resetting;
  // Transmit: host fills head, engine drains tail; receive the other way round
  assign headInc = s_r.txDir ? (advReq && !isFull) : (rxAcc && !isFull);
  assign tailInc = s_r.txDir ? (txSent && !isEmpty && !resetting) : (advReq && !isEmpty);
  assign overflowEv = rxAcc && isFull;
  assign efLevel = s_r.txDir ? isEmpty : isFull;
  assign halfLevel = halfCond(s_r.count, depth, s_r.txDir);
  assign nfneLevel = s_r.txDir ? !isFull : !isEmpty;
  // A full time stamp buffer stalls the engine's store
  assign rxStoreReady = !s_r.tsEn || bufInReady;
  assign bufPush = rxAcc && !isFull && s_r.tsEn;

  cmf_ptr #(.SLOT_W(SW)) u_head (
    .core_clk(core_clk),
    .rst(rst),
    .clr(resetting),
    .inc(headInc),
    .lastSlot(lastSlot),
    .value(headIdx)
  );

  cmf_ptr #(.SLOT_W(SW)) u_tail (
    .core_clk(core_clk),
    .rst(rst),
    .clr(resetting),
    .inc(tailInc),
    .lastSlot(lastSlot),
    .value(tailIdx)
  );

  cmf_buf #(.WIDTH(SW + TS_W), .DEPTH(BUF_DEPTH)) u_stamp (
    .core_clk(core_clk),
    .rst(rst),
    .flush(resetting),
    .inValid(bufPush),
    .inReady(bufInReady),
    .inData({headIdx, rxTimestamp}),
    .outValid(stampValid),
    .outReady(stampReady),
    .outData(stampData)
  );

  assign msgIndex = s_r.txDir ? tailIdx : headIdx;

  always_comb
  begin
    logic [cmf_pkg::WORD_W-1:0] ctrlWord;
    logic [cmf_pkg::WORD_W-1:0] statWord;
    logic [CW-1:0] cntNxt;
    ctrlWord = cmf_pkg::WORD_RESET;
    statWord = cmf_pkg::WORD_RESET;
    cntNxt = CW'(s_r.count + headInc - tailInc);
    s_nxt = s_r;
    s_nxt.abortPulse = 1'b0;
    s_nxt.count = cntNxt;

    unique case (s_r.st)
      cmf_pkg::ST_IDLE:
      begin
        if (configMode)
        begin
          s_nxt.st = cmf_pkg::ST_CFG;
        end
        else if (ctrlWr && regByteEn[cmf_pkg::LANE_HIGH] && regWdata[cmf_pkg::CTL_RESET_BIT])
        begin
          s_nxt.st = cmf_pkg::ST_CLEAR;
        end
      end
      cmf_pkg::ST_CLEAR:
      begin
        s_nxt.st = configMode ? cmf_pkg::ST_CFG : cmf_pkg::ST_IDLE;
      end
      cmf_pkg::ST_CFG:
      begin
        if (!configMode)
        begin
          s_nxt.st = cmf_pkg::ST_CLEAR;
        end
      end
      default:
      begin
        s_nxt.st = cmf_pkg::ST_CFG;
      end
    endcase

    // Software clears by writing zero; later hardware sets win
    if (statWr && regByteEn[cmf_pkg::LANE_LOW])
    begin
      s_nxt.aborted = s_r.aborted && regWdata[cmf_pkg::STA_ABORTED_BIT];
      s_nxt.arbLost = s_r.arbLost && regWdata[cmf_pkg::STA_ARB_BIT];
      s_nxt.busErr = s_r.busErr && regWdata[cmf_pkg::STA_BUSERR_BIT];
      s_nxt.attFlag = s_r.attFlag && regWdata[cmf_pkg::STA_ATT_BIT];
      s_nxt.ovfFlag = s_r.ovfFlag && regWdata[cmf_pkg::STA_OVF_BIT];
    end

    // Outcome of the message in flight, committed at its end
    if (s_r.txDir)
    begin
      s_nxt.pendArb = s_r.pendArb || txArbLost;
      s_nxt.pendErr = s_r.pendErr || txBusError;
      if (txSent || txAborted)
      begin
        s_nxt.aborted = txAborted;
        s_nxt.arbLost = s_r.pendArb || txArbLost;
        s_nxt.busErr = s_r.pendErr || txBusError;
        s_nxt.pendArb = 1'b0;
        s_nxt.pendErr = 1'b0;
      end
      if ((txSent && cntNxt == '0) || txAborted)
      begin
        s_nxt.sendReq = 1'b0;
      end
      if (txAttemptsExhausted)
      begin
        s_nxt.attFlag = 1'b1;
      end
    end
    if (overflowEv)
    begin
      s_nxt.ovfFlag = 1'b1;
    end

    if (ctrlWr && regByteEn[cmf_pkg::LANE_LOW])
    begin
      s_nxt.autoReply = regWdata[cmf_pkg::CTL_AUTO_RTR_BIT];
      s_nxt.attIe = regWdata[cmf_pkg::CTL_ATT_IE_BIT];
      s_nxt.ovfIe = regWdata[cmf_pkg::CTL_OVF_IE_BIT];
      s_nxt.efIe = regWdata[cmf_pkg::CTL_EF_IE_BIT];
      s_nxt.halfIe = regWdata[cmf_pkg::CTL_HALF_IE_BIT];
      s_nxt.nfneIe = regWdata[cmf_pkg::CTL_NFNE_IE_BIT];
      if (configMode)
      begin
        s_nxt.txDir = regWdata[cmf_pkg::CTL_DIR_BIT];
        s_nxt.tsEn = regWdata[cmf_pkg::CTL_TS_EN_BIT];
      end
    end

    // Send request is only meaningful for a transmit FIFO
    if (ctrlWr && regByteEn[cmf_pkg::LANE_HIGH] && s_r.txDir && !resetting)
    begin
      if (regWdata[cmf_pkg::CTL_SEND_BIT] && !s_r.sendReq)
      begin
        s_nxt.sendReq = 1'b1;
        s_nxt.aborted = 1'b0;
        s_nxt.arbLost = 1'b0;
        s_nxt.busErr = 1'b0;
      end
      else if (!regWdata[cmf_pkg::CTL_SEND_BIT] && s_r.sendReq)
      begin
        s_nxt.sendReq = 1'b0;
        s_nxt.abortPulse = 1'b1;
      end
    end
    if (remoteReqRcvd && s_r.autoReply && s_r.txDir && !resetting)
    begin
      s_nxt.sendReq = 1'b1;
    end

    if (resetting)
    begin
      s_nxt.count = '0;
      s_nxt.sendReq = 1'b0;
      s_nxt.aborted = 1'b0;
      s_nxt.arbLost = 1'b0;
      s_nxt.busErr = 1'b0;
      s_nxt.pendArb = 1'b0;
      s_nxt.pendErr = 1'b0;
      s_nxt.attFlag = 1'b0;
      s_nxt.ovfFlag = 1'b0;
      s_nxt.abortPulse = 1'b0;
    end

    s_nxt.irq = (s_r.attFlag && s_r.attIe)
                || (s_r.ovfFlag && s_r.ovfIe)
                || (efLevel && s_r.efIe)
                || (halfLevel && s_r.halfIe)
                || (nfneLevel && s_r.nfneIe);

    ctrlWord[cmf_pkg::CTL_RESET_BIT] = resetting;
    ctrlWord[cmf_pkg::CTL_SEND_BIT] = s_r.sendReq;
    ctrlWord[cmf_pkg::CTL_DIR_BIT] = s_r.txDir;
    ctrlWord[cmf_pkg::CTL_AUTO_RTR_BIT] = s_r.autoReply;
    ctrlWord[cmf_pkg::CTL_TS_EN_BIT] = s_r.tsEn;
    ctrlWord[cmf_pkg::CTL_ATT_IE_BIT] = s_r.attIe;
    ctrlWord[cmf_pkg::CTL_OVF_IE_BIT] = s_r.ovfIe;
    ctrlWord[cmf_pkg::CTL_EF_IE_BIT] = s_r.efIe;
    ctrlWord[cmf_pkg::CTL_HALF_IE_BIT] = s_r.halfIe;
    ctrlWord[cmf_pkg::CTL_NFNE_IE_BIT] = s_r.nfneIe;
    statWord[cmf_pkg::STA_INDEX_LSB +: cmf_pkg::INDEX_W] = msgIndex;
    statWord[cmf_pkg::STA_ABORTED_BIT] = s_r.aborted;
    statWord[cmf_pkg::STA_ARB_BIT] = s_r.arbLost;
    statWord[cmf_pkg::STA_BUSERR_BIT] = s_r.busErr;
    statWord[cmf_pkg::STA_ATT_BIT] = s_r.attFlag;
    statWord[cmf_pkg::STA_OVF_BIT] = s_r.ovfFlag;
    statWord[cmf_pkg::STA_EF_BIT] = efLevel;
    statWord[cmf_pkg::STA_HALF_BIT] = halfLevel;
    statWord[cmf_pkg::STA_NFNE_BIT] = nfneLevel;
    if (regRead)
    begin
      s_nxt.rdata = (regSel == cmf_pkg::SEL_CONTROL) ? ctrlWord : statWord;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.st <= cmf_pkg::ST_CFG;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign regRdata = s_r.rdata;
  assign sendRequest = s_r.sendReq;
  assign abortReq = s_r.abortPulse;
  assign resetBusy = resetting;
  assign txDirection = s_r.txDir;
  assign irqReq = s_r.irq;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_reset_done;
    (s_r.st == cmf_pkg::ST_CLEAR) && !configMode |=> !resetBusy && (s_r.count == '0);
  endproperty
  a_reset_done: assert property (p_reset_done) else $error("reset did not finish");

  property p_cfg_hold;
    configMode [*2] |-> resetBusy;
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("reset bit low in config");

  property p_rx_no_send;
    !txDirection |-> !sendRequest && !abortReq;
  endproperty
  a_rx_no_send: assert property (p_rx_no_send) else $error("send active in receive");

  property p_abort;
    ctrlWr && regByteEn[cmf_pkg::LANE_HIGH] && !regWdata[cmf_pkg::CTL_SEND_BIT]
      && sendRequest && txDirection && !resetBusy && !remoteReqRcvd |=> abortReq && !sendRequest;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not raised");

  property p_tx_head;
    txDirection && advReq && !isFull |=> headIdx != $past(headIdx) || $past(lastSlot) == '0;
  endproperty
  a_tx_head: assert property (p_tx_head) else $error("head did not move");

  property p_rx_tail;
    !txDirection && advReq && !isEmpty && !rxAcc |=> s_r.count == $past(s_r.count) - 1'b1;
  endproperty
  a_rx_tail: assert property (p_rx_tail) else $error("tail release lost");

  property p_dir_lock;
    !configMode |=> $stable(txDirection) && $stable(s_r.tsEn);
  endproperty
  a_dir_lock: assert property (p_dir_lock) else $error("direction changed outside config");

  property p_auto_reply;
    remoteReqRcvd && s_r.autoReply && txDirection && !resetBusy |=> sendRequest;
  endproperty
  a_auto_reply: assert property (p_auto_reply) else $error("remote reply not requested");

  property p_ts_gate;
    !s_r.tsEn |-> !bufPush;
  endproperty
  a_ts_gate: assert property (p_ts_gate) else $error("stamp without enable");

  property p_irq_mask;
    !s_r.attIe && !s_r.ovfIe && !s_r.efIe && !s_r.halfIe && !s_r.nfneIe |=> !irqReq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised");

  property p_arb_commit;
    txDirection && !resetBusy && txSent && (txArbLost || s_r.pendArb) |=> s_r.arbLost;
  endproperty
  a_arb_commit: assert property (p_arb_commit) else $error("arbitration loss lost");

  // Index follows the engine's side of the ring in either direction
  property p_index;
    !configMode && !resetBusy && (txDirection ? tailInc : headInc)
      |=> msgIndex != $past(msgIndex) || $past(lastSlot) == '0;
  endproperty
  a_index: assert property (p_index) else $error("index source wrong");

  c_abort: cover property (abortReq ##[1:20] txAborted);
  c_overflow: cover property (overflowEv);
  c_reset: cover property ((s_r.st == cmf_pkg::ST_IDLE) ##1 (s_r.st == cmf_pkg::ST_CLEAR));
  c_stall: cover property (s_r.tsEn && !rxStoreReady);
endmodule

//--- tb/cmf_engine_model.sv
// Protocol engine side model: consumes the stamp stream with optional stall
`timescale 1ns/1ns
module cmf_engine_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic holdOff,
  input wire logic stampValid,
  output logic stampReady,
  input wire logic [36:0] stampData,
  output logic [36:0] lastStamp,
  output logic [7:0] popCount
);
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      stampReady <= 1'b0;
      lastStamp <= 37'h0;
      popCount <= 8'h0;
    end
    else
    begin
      stampReady <= !holdOff;
      if (stampValid && stampReady)
      begin
        lastStamp <= stampData;
        popCount <= popCount + 8'h1;
      end
    end
  end
endmodule

//--- tb/can_msg_fifo_control_status_tb.sv
// Self-checking bench of the message FIFO control and status block
`timescale 1ns/1ns
module can_msg_fifo_control_status_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic configMode = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic regSel = 1'b0;
  logic [3:0] regByteEn = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata;
  logic [6:0] evt = 7'h0;
  logic [31:0] rxTimestamp = 32'h0;
  logic holdOff = 1'b1;
  logic rxStoreReady, sendRequest, abortReq, resetBusy, txDirection, irqReq;
  logic stampValid, stampReady;
  logic [4:0] headIdx, tailIdx, msgIndex;
  logic [36:0] stampData, lastStamp;
  logic [7:0] popCount;
  logic [31:0] d;
  int miscompares = 0;
  int samples_checked = 0;

  cmf_ctrl uut (.core_clk(core_clk), .rst(rst), .configMode(configMode),
    .regWrite(regWrite), .regRead(regRead), .regSel(regSel), .regByteEn(regByteEn),
    .regWdata(regWdata), .regRdata(regRdata), .lastSlot(5'h7), .txSent(evt[6]),
    .txAborted(evt[5]), .txArbLost(evt[4]), .txBusError(evt[3]),
    .txAttemptsExhausted(evt[2]), .remoteReqRcvd(evt[1]), .rxStore(evt[0]),
    .rxStoreReady(rxStoreReady), .rxTimestamp(rxTimestamp), .sendRequest(sendRequest),
    .abortReq(abortReq), .resetBusy(resetBusy), .txDirection(txDirection),
    .headIdx(headIdx), .tailIdx(tailIdx), .msgIndex(msgIndex), .irqReq(irqReq),
    .stampValid(stampValid), .stampReady(stampReady), .stampData(stampData));
  cmf_engine_model model (.core_clk(core_clk), .rst(rst), .holdOff(holdOff),
    .stampValid(stampValid), .stampReady(stampReady), .stampData(stampData),
    .lastStamp(lastStamp), .popCount(popCount));

  initial
  begin
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic s, input logic [3:0] be, input logic [31:0] v);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regSel <= s;
    regByteEn <= be;
    regWdata <= v;
    @(posedge core_clk);
    regWrite <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic s);
    @(posedge core_clk);
    regRead <= 1'b1;
    regSel <= s;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask

  task automatic ev(input logic [6:0] v);
    @(posedge core_clk);
    evt <= v;
    @(posedge core_clk);
    evt <= 7'h0;
    #1;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (resetBusy !== 1'b0 && n < 8)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(resetBusy, 1'b0);
  endtask

  task automatic t_config;
    chk(resetBusy, 1'b1);
    rd(1'b0);
    chk(d[10], 1'b1);
    wr(1'b0, 4'h1, 32'h80);
    @(posedge core_clk);
    configMode <= 1'b0;
    wait_idle();
    chk(txDirection, 1'b1);
    wr(1'b0, 4'h1, 32'h0);
    chk(txDirection, 1'b1);
  endtask

  task automatic t_tx;
    wr(1'b0, 4'h2, 32'h100);
    wr(1'b0, 4'h2, 32'h100);
    chk(headIdx, 5'h2);
    wr(1'b0, 4'h2, 32'h200);
    chk(sendRequest, 1'b1);
    ev(7'h10);
    ev(7'h40);
    chk(sendRequest, 1'b1);
    rd(1'b1);
    chk(d & 32'h1fe0, 32'h0140);
    ev(7'h40);
    chk(sendRequest, 1'b0);
    chk(msgIndex, 5'h2);
    rd(1'b1);
    chk(d[6], 1'b0);
  endtask

  task automatic t_abort;
    logic seen;
    wr(1'b0, 4'h1, 32'hc0);
    wr(1'b0, 4'h2, 32'h100);
    ev(7'h02);
    chk(sendRequest, 1'b1);
    wr(1'b0, 4'h2, 32'h0);
    seen = abortReq;
    chk(sendRequest, 1'b0);
    @(posedge core_clk);
    #1;
    chk(seen | abortReq, 1'b1);
    ev(7'h08);
    ev(7'h20);
    rd(1'b1);
    chk(d[7:5], 3'h5);
  endtask

  task automatic t_irq;
    wr(1'b0, 4'h1, 32'h80);
    ev(7'h04);
    @(posedge core_clk);
    #1;
    chk(irqReq, 1'b0);
    wr(1'b0, 4'h1, 32'h90);
    @(posedge core_clk);
    #1;
    chk(irqReq, 1'b1);
    rd(1'b0);
    chk(d[10:0], 11'h090);
    wr(1'b1, 4'h1, 32'h0);
    @(posedge core_clk);
    #1;
    chk(irqReq, 1'b0);
  endtask

  task automatic t_rx;
    @(posedge core_clk);
    configMode <= 1'b1;
    wr(1'b0, 4'h1, 32'h20);
    @(posedge core_clk);
    configMode <= 1'b0;
    wait_idle();
    chk(txDirection, 1'b0);
    wr(1'b0, 4'h2, 32'h200);
    chk(sendRequest, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk);
      evt <= 7'h01;
      rxTimestamp <= 32'h1000 + i;
      @(posedge core_clk);
      evt <= 7'h0;
    end
    #1;
    chk(rxStoreReady, 1'b0);
    chk(msgIndex, 5'h4);
    chk(stampData, {5'h0, 32'h1000});
    holdOff <= 1'b0;
    for (int n = 0; n < 20 && popCount !== 8'h4; n++)
    begin
      @(posedge core_clk);
      #1;
    end
    chk(lastStamp, {5'h3, 32'h1003});
    chk(stampValid, 1'b0);
    wr(1'b0, 4'h2, 32'h100);
    chk(tailIdx, 5'h1);
    wr(1'b0, 4'h1, 32'h21);
    @(posedge core_clk);
    #1;
    chk(irqReq, 1'b1);
  endtask

  task automatic t_ovf;
    wr(1'b0, 4'h1, 32'h2e);
    repeat (5) ev(7'h01);
    rd(1'b1);
    chk(d[12:0], 13'h0107);
    wr(1'b0, 4'h1, 32'h28);
    @(posedge core_clk);
    #1;
    chk(irqReq, 1'b0);
    ev(7'h01);
    @(posedge core_clk);
    #1;
    chk(irqReq, 1'b1);
    chk(msgIndex, 5'h1);
    rd(1'b1);
    chk(d[4:0], 5'h0f);
  endtask

  task automatic t_fifo_reset_req;
    wr(1'b0, 4'h2, 32'h400);
    chk(resetBusy, 1'b1);
    @(posedge core_clk);
    #1;
    chk(resetBusy, 1'b0);
    chk({headIdx, tailIdx}, 10'h0);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    miscompares++;
    wrap_up();
  end

  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    t_config();
    t_tx();
    t_abort();
    t_irq();
    t_rx();
    t_ovf();
    t_fifo_reset_req();
    wrap_up();
  end
endmodule
